// ===== logic/loader_host.sv
// Host end: Wishbone registers driving the three-wire program link
//
// The Wishbone interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module loader_host
    import loader_pkg::*;
#(
    parameter int HALF = loader_pkg::LINK_HALF_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    prog_link_if.host        link,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o
);
    import loader_pkg::*;

    if (HALF < 1 || HALF > 7) begin : g_chk
        $error("HALF must lie in 1..7");
    end

    localparam logic [3:0] HALF_END   = 4'(HALF - 1);
    localparam logic [3:0] SETTLE_END = 4'(2 * HALF - 1);

    // Bus slave, one wait cycle, write takes effect at the ack edge
    logic ack_r;
    logic acc;
    logic wr;

    assign acc = wb_cyc_i & wb_stb_i;
    assign wr  = acc & wb_we_i & ack_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= acc & ~ack_r;
        end
    end
    assign wb_ack_o = ack_r;

    logic [31:0]     prog_r;
    logic [EV_W-1:0] irq_st_r;
    logic [EV_W-1:0] irq_en_r;
    logic [EV_W-1:0] ev;
    logic            lock_s;
    host_state_t     st_r;
    logic            go;
    logic            retrig;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prog_r <= PROG_RST;
        end else if (wr && wb_adr_i == REG_PROG) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b]) begin
                    prog_r[8*b +: 8] <= wb_dat_i[8*b +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_en_r <= IRQ_EN_RST;
        end else if (wr && wb_adr_i == REG_IRQ_EN && wb_sel_i[0]) begin
            irq_en_r <= wb_dat_i[EV_W-1:0];
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_st_r <= '0;
        end else if (wr && wb_adr_i == REG_IRQ_CLR && wb_sel_i[0]) begin
            irq_st_r <= (irq_st_r & ~wb_dat_i[EV_W-1:0]) | ev;
        end else begin
            irq_st_r <= irq_st_r | ev;
        end
    end
    assign irq_o = |(irq_st_r & irq_en_r);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (acc && !ack_r) begin
            case (wb_adr_i)
                REG_PROG:   wb_dat_o <= prog_r;
                REG_STATUS: wb_dat_o <= {30'd0, lock_s, st_r != H_IDLE};
                REG_IRQ_ST: wb_dat_o <= {29'd0, irq_st_r};
                REG_IRQ_EN: wb_dat_o <= {29'd0, irq_en_r};
                default:    wb_dat_o <= '0;
            endcase
        end
    end

    // Orders are taken only while idle
    assign go     = wr && wb_adr_i == REG_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_GO];
    assign retrig = wr && wb_adr_i == REG_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_RETRIG];

    sync_2ff #(
        .W (1)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (link.lock_ind),
        .sync_o  (lock_s)
    );

    // Link sequencer, serial clock divided from clk_i
    logic [31:0] tx_r;
    logic [5:0]  left_r;
    logic [3:0]  tmr_r;
    logic        sel_r;
    logic        sck_r;
    logic        sdi_r;
    logic        pair_ok;
    logic        half_done;

    assign pair_ok   = wrap_pair_ok(prog_r[NUM_LSB +: 3], prog_r[DEN_LSB +: 3]);
    assign half_done = (tmr_r == HALF_END);

    always_ff @(posedge clk_i) begin
        if (rst_i || st_r == H_IDLE || st_r == H_WAIT) begin
            tmr_r <= '0;
        end else if (half_done && st_r != H_SETTLE) begin
            tmr_r <= '0;
        end else begin
            tmr_r <= tmr_r + 4'd1;
        end
    end

    always_ff @(posedge clk_i) begin
        ev <= '0;
        if (rst_i) begin
            st_r   <= H_IDLE;
            sel_r  <= 1'b0;
            sck_r  <= 1'b0;
            sdi_r  <= 1'b0;
            tx_r   <= PROG_RST;
            left_r <= '0;
        end else begin
            case (st_r)
                H_IDLE: begin
                    if (go && !pair_ok) begin
                        ev[EV_REJECT] <= 1'b1; // RULE15
                    end else if (go || retrig) begin
                        sel_r  <= 1'b1; // RULE6
                        tx_r   <= prog_r & ~FIXED_ZERO_MASK; // RULE9 RULE13
                        left_r <= go ? 6'(PROG_BITS) : 6'd0; // RULE5
                        st_r   <= H_LEAD;
                    end
                end
                H_LEAD: if (half_done) begin
                    st_r <= (left_r == 6'd0) ? H_TAIL : H_LOW;
                end
                H_LOW: begin
                    sdi_r <= tx_r[31]; // RULE7 RULE8
                    if (half_done) begin
                        sck_r <= 1'b1;
                        st_r  <= H_HIGH;
                    end
                end
                H_HIGH: if (half_done) begin
                    sck_r  <= 1'b0;
                    tx_r   <= {tx_r[30:0], 1'b0};
                    left_r <= left_r - 6'd1;
                    st_r   <= (left_r == 6'd1) ? H_TAIL : H_LOW;
                end
                H_TAIL: if (half_done) begin
                    sel_r        <= 1'b0; // RULE4
                    sdi_r        <= 1'b0;
                    ev[EV_SENT]  <= 1'b1;
                    st_r         <= H_SETTLE;
                end
                H_SETTLE: if (tmr_r == SETTLE_END) begin
                    st_r <= H_WAIT;
                end
                H_WAIT: if (lock_s) begin // RULE10
                    ev[EV_LOCK] <= 1'b1;
                    st_r        <= H_IDLE;
                end
                default: st_r <= H_IDLE;
            endcase
        end
    end

    assign link.prog_select       = sel_r;
    assign link.serial_prog_clock = sck_r;
    assign link.serial_prog_in    = sdi_r;
endmodule : loader_host

// ===== logic/loader_pkg.sv
// Shared constants, types and decode functions for the serial program link
package loader_pkg;
    localparam int PROG_BITS = 32;
    // Field positions in the program word, first bit sent is bit 31
    localparam int PRE_LSB  = 28;
    localparam int GA_LSB   = 23;
    localparam int GB_LSB   = 18;
    localparam int FD_LSB   = 14;
    localparam int RSV_LSB  = 11;
    localparam int POST_LSB = 6;
    localparam int NUM_LSB  = 3;
    localparam int DEN_LSB  = 0;
    localparam logic [31:0] FIXED_ZERO_MASK = 32'hF000_3800;
    localparam logic [31:0] PROG_RST        = 32'h0000_0000;
    // Link timing
    localparam int CLK_PERIOD_NS  = 50;
    localparam int LINK_PERIOD_NS = 400;
    localparam int LINK_HALF_CYC  = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int LOCK_QUAL_CYC  = 256;
    // Wrapper divisor limits
    localparam logic [5:0]  BIG_SET_MIN = 6'd31;
    localparam logic [10:0] RATIO_NUM   = 11'd17;
    localparam logic [10:0] RATIO_DEN   = 11'd14;
    // Host register map, byte addresses
    localparam logic [7:0] REG_PROG    = 8'h00;
    localparam logic [7:0] REG_CTRL    = 8'h04;
    localparam logic [7:0] REG_STATUS  = 8'h08;
    localparam logic [7:0] REG_IRQ_ST  = 8'h0C;
    localparam logic [7:0] REG_IRQ_CLR = 8'h10;
    localparam logic [7:0] REG_IRQ_EN  = 8'h14;
    localparam int CTRL_GO      = 0;
    localparam int CTRL_RETRIG  = 1;
    localparam int ST_BUSY      = 0;
    localparam int ST_LOCK      = 1;
    localparam int EV_SENT      = 0;
    localparam int EV_LOCK      = 1;
    localparam int EV_REJECT    = 2;
    localparam int EV_W         = 3;
    localparam logic [2:0] IRQ_EN_RST = 3'h0;

    typedef enum {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_TAIL, H_SETTLE, H_WAIT}
        host_state_t;

    function automatic logic [5:0] wrap_divisor(input logic [2:0] sel);
        case (sel)
            3'h2:    wrap_divisor = 6'd18;
            3'h3:    wrap_divisor = 6'd17;
            3'h4:    wrap_divisor = 6'd31;
            3'h5:    wrap_divisor = 6'd14;
            3'h6:    wrap_divisor = 6'd32;
            3'h7:    wrap_divisor = 6'd15;
            default: wrap_divisor = 6'd16;
        endcase
    endfunction : wrap_divisor

    // Same divisor set and N/M below 17/14
    function automatic logic wrap_pair_ok(input logic [2:0] n, input logic [2:0] m);
        logic [5:0] dn;
        logic [5:0] dm;
        dn = wrap_divisor(n);
        dm = wrap_divisor(m);
        wrap_pair_ok = ((dn >= BIG_SET_MIN) == (dm >= BIG_SET_MIN)) &&
                       ({5'd0, dn} * RATIO_DEN < {5'd0, dm} * RATIO_NUM);
    endfunction : wrap_pair_ok
endpackage : loader_pkg

// ===== logic/prog_link_if.sv
// Three-wire program link plus lock indicator between host and device
`timescale 1ns/1ps
interface prog_link_if;
    logic prog_select;
    logic serial_prog_clock;
    logic serial_prog_in;
    logic lock_ind;

    modport host (
        output prog_select,
        output serial_prog_clock,
        output serial_prog_in,
        input  lock_ind
    );
    modport device (
        input  prog_select,
        input  serial_prog_clock,
        input  serial_prog_in,
        output lock_ind
    );
endinterface : prog_link_if

// ===== logic/sync_2ff.sv
// Two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
module sync_2ff #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_r;

    if (W < 1) begin : g_chk
        $error("sync_2ff width must be at least 1");
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= '0;
            sync_o <= '0;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule : sync_2ff

// ===== logic/loader_device.sv
// Device end: serial program capture, acquisition start and lock indicator
//
// How it works
// RULE1: one data bit per serial clock rise
// RULE2: select low ignores data, register holds
// RULE3: select high shifts bits into register
// RULE4: select fall starts acquisition with program
// RULE5: select pulse alone restarts acquisition, same program
// RULE6: host raises select before any bit
// RULE7: fixed 32-bit field order, preamble first
// RULE8: each field arrives most significant bit first
// RULE9: host sends preamble and reserved as zero
// RULE10: host waits for lock before using output
// RULE11: standard program yields 155.52 MHz output
// RULE12: second standard program yields 156.25 MHz output
// RULE13: host changes only wrapper fields for wrapper
// RULE14: wrapper selects decode to fixed divisors
// RULE15: host keeps divisor pair same set, ratio
// RULE16: lock only when both loops locked
// RULE17: last 32 bits kept, active until next fall
`timescale 1ns/1ps
module loader_device
    import loader_pkg::*;
#(
    parameter int LOCK_QUAL = loader_pkg::LOCK_QUAL_CYC
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    prog_link_if.device     link,
    input  wire logic       frac_lock_i,
    input  wire logic       wrap_lock_i,
    output logic            acq_start_o,
    output logic            acquiring_o,
    output logic            lock_o,
    output logic            bad_len_o,
    output logic [4:0]      gate_count_a_o,
    output logic [4:0]      gate_count_b_o,
    output logic [3:0]      frac_divide_sel_o,
    output logic [4:0]      output_post_divider_select_o,
    output logic [2:0]      wrapper_numerator_select_o,
    output logic [2:0]      wrapper_denominator_select_o,
    output logic [5:0]      num_divisor_o,
    output logic [5:0]      den_divisor_o
);
    import loader_pkg::*;

    localparam int QW = $clog2(LOCK_QUAL + 1);
    localparam logic [QW-1:0] QUAL_MAX = QW'(LOCK_QUAL);
    localparam logic [5:0] CNT_MAX = 6'd63;
    localparam logic [5:0] CNT_FULL = 6'(PROG_BITS);

    if (LOCK_QUAL < 1) begin : g_chk
        $error("LOCK_QUAL must be at least 1");
    end

    // Link pins cross into the local clock
    logic [2:0] pins_s;
    logic       sel_s;
    logic       sck_s;
    logic       sdi_s;
    logic       sel_d_r;
    logic       sck_d_r;
    logic       sck_rise;
    logic       sel_rise;
    logic       sel_fall;

    sync_2ff #(
        .W (3)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({link.prog_select, link.serial_prog_clock, link.serial_prog_in}),
        .sync_o  (pins_s)
    );

    assign sel_s = pins_s[2];
    assign sck_s = pins_s[1];
    assign sdi_s = pins_s[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_d_r <= 1'b0;
            sck_d_r <= 1'b0;
        end else begin
            sel_d_r <= sel_s;
            sck_d_r <= sck_s;
        end
    end

    assign sck_rise = sck_s & ~sck_d_r;
    assign sel_rise = sel_s & ~sel_d_r;
    assign sel_fall = ~sel_s & sel_d_r;

    // Shift register, first bit ends up in bit 31
    logic [31:0] shift_r;
    logic [5:0]  cnt_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift_r <= PROG_RST;
        end else if (sel_s && sck_rise) begin // RULE1 RULE3
            shift_r <= {shift_r[30:0], sdi_s}; // RULE8 RULE17
        end
    end // RULE2

    // Bits seen during one select-high period
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= '0;
        end else if (sel_rise) begin
            cnt_r <= '0;
        end else if (sel_s && sck_rise && cnt_r != CNT_MAX) begin
            cnt_r <= cnt_r + 6'd1;
        end
    end

    // Active program, replaced only on select fall
    logic [31:0] prog_r;
    logic        bad_len_r;
    logic        acq_start_r;
    logic [5:0]  num_div_r;
    logic [5:0]  den_div_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prog_r <= PROG_RST;
        end else if (sel_fall) begin // RULE4 RULE5
            prog_r <= shift_r; // RULE17
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bad_len_r <= 1'b0;
        end else if (sel_fall) begin
            bad_len_r <= (cnt_r != CNT_FULL) && (cnt_r != 6'd0); // RULE17
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acq_start_r <= 1'b0;
        end else begin
            acq_start_r <= sel_fall; // RULE4 RULE5
        end
    end

    // Wrapper divisors decoded from the stored selects
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            num_div_r <= wrap_divisor(PROG_RST[NUM_LSB +: 3]);
            den_div_r <= wrap_divisor(PROG_RST[DEN_LSB +: 3]);
        end else if (sel_fall) begin
            num_div_r <= wrap_divisor(shift_r[NUM_LSB +: 3]); // RULE14
            den_div_r <= wrap_divisor(shift_r[DEN_LSB +: 3]); // RULE14
        end
    end

    // Field split of the active program
    assign gate_count_a_o               = prog_r[GA_LSB +: 5]; // RULE7
    assign gate_count_b_o               = prog_r[GB_LSB +: 5]; // RULE7
    assign frac_divide_sel_o            = prog_r[FD_LSB +: 4]; // RULE7
    assign output_post_divider_select_o = prog_r[POST_LSB +: 5]; // RULE7 RULE11 RULE12
    assign wrapper_numerator_select_o   = prog_r[NUM_LSB +: 3]; // RULE7
    assign wrapper_denominator_select_o = prog_r[DEN_LSB +: 3]; // RULE7
    assign num_divisor_o                = num_div_r;
    assign den_divisor_o                = den_div_r;
    assign bad_len_o                    = bad_len_r;
    assign acq_start_o                  = acq_start_r;

    // Lock qualification per loop, restarted by each acquisition
    logic [QW-1:0] qual_r [2];
    logic [1:0]    loop_ok;
    logic [1:0]    declared;
    logic          acquiring_r;
    logic          lock_r;

    assign loop_ok = {wrap_lock_i, frac_lock_i};

    always_ff @(posedge clk_i) begin
        for (int i = 0; i < 2; i++) begin
            if (rst_i || acq_start_r || !loop_ok[i]) begin
                qual_r[i] <= '0;
            end else if (qual_r[i] != QUAL_MAX) begin
                qual_r[i] <= qual_r[i] + QW'(1);
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            declared[i] = (qual_r[i] == QUAL_MAX);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acquiring_r <= 1'b0;
        end else if (acq_start_r) begin
            acquiring_r <= 1'b1;
        end else if (&declared) begin
            acquiring_r <= 1'b0;
        end
    end

    // Lock drops at once when a new acquisition starts
    always_ff @(posedge clk_i) begin
        if (rst_i || sel_fall || acq_start_r) begin
            lock_r <= 1'b0;
        end else begin
            lock_r <= &declared; // RULE16
        end
    end

    assign acquiring_o   = acquiring_r;
    assign lock_o        = lock_r;
    assign link.lock_ind = lock_r;
endmodule : loader_device

// ===== sim/link_sva.sv
// Protocol checker watching the host-to-device program link
`timescale 1ns/1ps
module link_sva (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic prog_select,
    input  wire logic serial_prog_clock,
    input  wire logic serial_prog_in,
    input  wire logic lock_ind
);
    logic [5:0] bit_r;
    logic       sck_r;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Bits sent in the current select period
    always_ff @(posedge clk_i) begin
        if (rst_i || !prog_select) begin
            bit_r <= 6'h0;
        end else if (serial_prog_clock && !sck_r) begin
            bit_r <= bit_r + 6'h1;
        end
    end
    always_ff @(posedge clk_i) begin
        sck_r <= rst_i ? 1'b0 : serial_prog_clock;
    end

    sel_lead_a: assert property ($rose(prog_select) |-> !serial_prog_clock [*8])
        else $error("serial clock moved during select lead");
    sck_idle_a: assert property (!prog_select |-> !serial_prog_clock)
        else $error("serial clock moved with select low");
    sck_high_a: assert property (
        $rose(serial_prog_clock) |-> serial_prog_clock [*4] ##1 !serial_prog_clock)
        else $error("serial clock high phase wrong");
    data_hold_a: assert property (
        serial_prog_clock && $past(serial_prog_clock) |-> $stable(serial_prog_in))
        else $error("data changed while clock high");
    zero_field_a: assert property (
        $rose(serial_prog_clock) && (bit_r < 6'd4 || (bit_r >= 6'd18 && bit_r <= 6'd20))
        |-> !serial_prog_in)
        else $error("preamble or reserved bit not zero");
    bit_count_a: assert property ($fell(prog_select) && bit_r != 6'h0 |-> bit_r == 6'd32)
        else $error("frame bit count not 32");
    lock_drop_a: assert property ($fell(prog_select) |-> ##[1:8] !lock_ind)
        else $error("lock held over a new acquisition");
    lock_rise_a: assert property (
        $rose(lock_ind) |-> !prog_select && !$past(prog_select, 8))
        else $error("lock rose too soon after select");
endmodule : link_sva

// ===== sim/testbench.sv
// Bench joining host and device ends, plus a hand-driven second link
`timescale 1ns/1ps
module testbench;
    import loader_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, irq_o, acq1, acq2, lock1, bad2, acq_lvl;
    logic        frac_lock_i = 1'b1;
    logic        wrap_lock_i = 1'b1;
    wire logic [24:0] f1, f2;
    wire logic [5:0]  ndiv, ddiv;
    int          error_cnt = 0;
    int          checks = 0;
    int          acq_cnt = 0;
    int          far_cnt = 0;
    logic [5:0]  dtab [8] = '{6'h10, 6'h10, 6'h12, 6'h11, 6'h1F, 6'h0E, 6'h20, 6'h0F};
    localparam logic [31:0] W155 = 32'h00E1_C12D;
    localparam logic [31:0] W156 = 32'h025D_C12D;

    prog_link_if l1();
    prog_link_if l2();
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (acq1 === 1'b1) acq_cnt++;
        if (acq2 === 1'b1) far_cnt++;
    end

    loader_host u_loader_host (.clk_i(clk_i), .rst_i(rst_i), .link(l1), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));
    loader_device #(.LOCK_QUAL(8)) u_loader_device (.clk_i(clk_i), .rst_i(rst_i), .link(l1),
        .frac_lock_i(frac_lock_i), .wrap_lock_i(wrap_lock_i), .acq_start_o(acq1),
        .acquiring_o(acq_lvl), .lock_o(lock1), .bad_len_o(), .gate_count_a_o(f1[24:20]),
        .gate_count_b_o(f1[19:15]), .frac_divide_sel_o(f1[14:11]),
        .output_post_divider_select_o(f1[10:6]), .wrapper_numerator_select_o(f1[5:3]),
        .wrapper_denominator_select_o(f1[2:0]), .num_divisor_o(ndiv), .den_divisor_o(ddiv));
    loader_device #(.LOCK_QUAL(8)) u_loader_device_b (.clk_i(clk_i), .rst_i(rst_i), .link(l2),
        .frac_lock_i(1'b0), .wrap_lock_i(1'b0), .acq_start_o(acq2), .acquiring_o(),
        .lock_o(), .bad_len_o(bad2), .gate_count_a_o(f2[24:20]), .gate_count_b_o(f2[19:15]),
        .frac_divide_sel_o(f2[14:11]), .output_post_divider_select_o(f2[10:6]),
        .wrapper_numerator_select_o(f2[5:3]), .wrapper_denominator_select_o(f2[2:0]),
        .num_divisor_o(), .den_divisor_o());
    link_sva u_link_sva (.clk_i(clk_i), .rst_i(rst_i), .prog_select(l1.prog_select),
        .serial_prog_clock(l1.serial_prog_clock), .serial_prog_in(l1.serial_prog_in),
        .lock_ind(l1.lock_ind));

    function automatic logic [24:0] fl(input logic [31:0] w);
        return {w[27:14], w[10:0]};
    endfunction : fl

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 100);
        q = wb_dat_o;
        chk("wb ack", 32'h1, {31'h0, wb_ack_o});
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 32'h0000_0000, q);
        chk(what, exp, q);
    endtask : rd_chk

    // Send a program and wait until the host reports idle
    task automatic run(input logic [31:0] w, input logic [31:0] ctrl);
        logic [31:0] q;
        int n;
        n = 0;
        wr(REG_PROG, w);
        wr(REG_CTRL, ctrl);
        do begin
            wb(1'b0, REG_STATUS, 32'h0000_0000, q);
            n++;
        end while (q[ST_BUSY] !== 1'b0 && n < 2000);
        chk("busy", 32'h0, {31'h0, q[ST_BUSY]});
    endtask : run

    task automatic t_regs();
        rd_chk("irq enable reset", REG_IRQ_EN, 32'h0000_0000);
        wr(REG_IRQ_EN, 32'h0000_0005);
        rd_chk("irq enable", REG_IRQ_EN, 32'h0000_0005);
        wr(8'h20, 32'hFFFF_FFFF);
        rd_chk("unmapped", 8'h20, 32'h0000_0000);
        wr(REG_IRQ_EN, 32'h0000_0000);
    endtask : t_regs

    task automatic t_std(input logic [31:0] w);
        int a;
        a = acq_cnt;
        run(w | FIXED_ZERO_MASK, 32'h0000_0001);
        chk("fields", fl(w), f1);
        chk("divisors", {20'h0, 6'h0E, 6'h0E}, {20'h0, ndiv, ddiv});
        chk("starts", a + 1, acq_cnt);
        chk("lock", 32'h1, {31'h0, lock1});
        rd_chk("status", REG_STATUS, 32'h0000_0002);
        rd_chk("irq status", REG_IRQ_ST, 32'h0000_0003);
        chk("irq masked", 32'h0, {31'h0, irq_o});
        wr(REG_IRQ_EN, 32'h0000_0002);
        chk("irq raised", 32'h1, {31'h0, irq_o});
        wr(REG_IRQ_CLR, 32'h0000_0003);
        chk("irq cleared", 32'h0, {31'h0, irq_o});
        rd_chk("irq status clr", REG_IRQ_ST, 32'h0000_0000);
        wr(REG_IRQ_EN, 32'h0000_0000);
    endtask : t_std

    task automatic t_reject();
        int a;
        a = acq_cnt;
        run({W155[31:6], 6'b010_101}, 32'h0000_0001);
        rd_chk("reject flag", REG_IRQ_ST, 32'h0000_0004);
        chk("no start", a, acq_cnt);
        wr(REG_IRQ_CLR, 32'h0000_0007);
    endtask : t_reject

    task automatic t_retrig();
        int a;
        int n;
        a = acq_cnt;
        wrap_lock_i <= 1'b0;
        wr(REG_CTRL, 32'h0000_0002);
        repeat (100) @(posedge clk_i);
        chk("one loop lock", 32'h0, {31'h0, lock1});
        chk("acquiring", 32'h1, {31'h0, acq_lvl});
        chk("restart", a + 1, acq_cnt);
        chk("same program", fl(W156), f1);
        wrap_lock_i <= 1'b1;
        n = 0;
        while (lock1 !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        chk("relock", 32'h1, {31'h0, lock1});
        chk("acquired", 32'h0, {31'h0, acq_lvl});
        run(W156, 32'h0000_0000);
        wr(REG_IRQ_CLR, 32'h0000_0007);
    endtask : t_retrig

    // Hand-driven frame on the second link; data inverted once released
    task automatic send(input logic [39:0] w, input int nb, input logic sel);
        l2.prog_select <= sel;
        repeat (4) @(posedge clk_i);
        for (int i = nb - 1; i >= 0; i--) begin
            l2.serial_prog_in    <= w[i];
            l2.serial_prog_clock <= 1'b0;
            repeat (4) @(posedge clk_i);
            l2.serial_prog_clock <= 1'b1;
            repeat (4) @(posedge clk_i);
        end
        l2.serial_prog_clock <= 1'b0;
        repeat (4) @(posedge clk_i);
        l2.prog_select    <= 1'b0;
        l2.serial_prog_in <= ~w[0];
        repeat (12) @(posedge clk_i);
    endtask : send

    task automatic t_far();
        send({8'h00, W155}, 32, 1'b1);
        chk("far fields", fl(W155), f2);
        chk("far start", 32'd1, far_cnt);
        send({8'h00, W156}, 32, 1'b0);
        chk("select low", fl(W155), f2);
        chk("no far start", 32'd1, far_cnt);
        send({8'hA5, W156}, 40, 1'b1);
        chk("last 32", fl(W156), f2);
        chk("bad length", 32'h1, {31'h0, bad2});
        send({8'h00, W155}, 32, 1'b1);
        chk("good length", 32'h0, {31'h0, bad2});
    endtask : t_far

    task automatic summarize();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize

    initial begin
        l2.prog_select       = 1'b0;
        l2.serial_prog_clock = 1'b0;
        l2.serial_prog_in    = 1'b0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs();
        t_std(W155);
        t_std(W156);
        for (int s = 0; s < 8; s++) begin
            run({W155[31:6], s[2:0], s[2:0]}, 32'h0000_0001);
            chk("decode", {20'h0, dtab[s], dtab[s]}, {20'h0, ndiv, ddiv});
            wr(REG_IRQ_CLR, 32'h0000_0007);
        end
        t_reject();
        run(W156, 32'h0000_0001);
        t_retrig();
        t_far();
        summarize();
    end

    initial begin
        repeat (60000) @(posedge clk_i);
        error_cnt++;
        summarize();
    end
endmodule : testbench
